// [logic/mdr_decoder.sv]
// Multiply-accumulate to data register decoder with APB register access
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "mdr_cfg.svh"
`default_nettype none

// Behaviour
// - Opcode plus 0x0800_0000 is accepted as the parallel-issue form.
// - Half select picks which 16-bit source halves are multiplied.
// - Destination field names the data register receiving the result.
// - Left operand field names the register of the left multiplicand.
// - Right operand field names the register of the right multiplicand.
// - 0xC10D_0800 range: add to accumulator zero, integer signed, even.
// - 0xC10D_1000 range: subtract from accumulator zero, integer signed.
// - 0xC12D_1000..17FF: subtract, accumulator zero, saturate x2, even.
// - 0xC109_1800..D9FF: add to accumulator one, integer signed, odd.
// - 0xC119_1800 range: add accumulator one, signed, mixed operands.
// - 0xC039_1800 range: add accumulator one, scale2 round, mixed.
// - 0xC09A_1800 range: subtract accumulator one, fraction, mixed.
// - Accumulator one results always go to an odd data register.
module mdr_decoder #(
  parameter int AW = 12,
  parameter int CW = 32
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [AW-1:0]           paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    insn_valid,
  input  wire logic [31:0]             insn_word,
  output logic                         dec_valid,
  output mdr_pkg::mdr_dec_t            dec
);

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [31:0]       ctrl_ff;
  logic [31:0]       inject_ff;
  logic              pend_ff;
  logic [31:0]       word_ff;
  logic [CW-1:0]     hits_ff;
  logic [CW-1:0]     miss_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic [31:0]       prdata_ff;
  logic              dec_valid_ff;
  mdr_pkg::mdr_dec_t dec_ff;

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  wire logic        acc_ph   = psel & penable;
  wire logic        done     = acc_ph & pready_ff;
  wire logic        wr_done  = done & pwrite;
  wire logic [11:0] ofs      = paddr[11:0];
  wire logic        sel_ctrl = ofs == `MDR_OFS_CTRL;
  wire logic        sel_inj  = ofs == `MDR_OFS_INJECT;
  wire logic        sel_word = ofs == `MDR_OFS_WORD;
  wire logic        sel_res  = ofs == `MDR_OFS_RESULT;
  wire logic        sel_hits = ofs == `MDR_OFS_HITS;
  wire logic        sel_miss = ofs == `MDR_OFS_MISSES;
  wire logic        mapped   = sel_ctrl | sel_inj | sel_word | sel_res |
                               sel_hits | sel_miss;
  wire logic        ro_sel   = sel_word | sel_res;

  wire logic [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                                 {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic [31:0] nxt_ctrl  = (ctrl_ff & ~lane_mask) |
                                (pwdata & lane_mask);
  wire logic [31:0] nxt_inj   = (inject_ff & ~lane_mask) |
                                (pwdata & lane_mask);

  wire logic wr_ctrl   = wr_done & sel_ctrl;
  wire logic wr_inj    = wr_done & sel_inj;
  wire logic clr_hits  = wr_done & sel_hits;
  wire logic clr_miss  = wr_done & sel_miss;

  wire logic dec_en    = ctrl_ff[`MDR_CTRL_EN_BIT];
  wire logic par_en    = ctrl_ff[`MDR_CTRL_PAR_BIT];

  // ***************************************************************
  // Source of the word to decode
  // ***************************************************************
  // Fetch words go first; an injected word waits in inject_ff while pend_ff is set
  wire logic        take_fetch = insn_valid & dec_en;
  wire logic        take_inj   = pend_ff & ~take_fetch;
  wire logic        take       = take_fetch | take_inj;
  wire logic [31:0] src_word   = take_fetch ? insn_word : inject_ff;

  // ***************************************************************
  // Opcode recognition
  // ***************************************************************
  wire logic        par_form = src_word[`MDR_PAR_BIT];
  logic      [31:0] base_word;

  always_comb begin
    base_word = src_word;
    base_word[`MDR_PAR_BIT] = 1'b0;
  end

  wire logic h_acc0_add;
  wire logic h_acc0_sub;
  wire logic h_acc0_sat;
  wire logic h_acc1_sgn;
  wire logic h_acc1_sgnm;
  wire logic h_acc1_s2m;
  wire logic h_acc1_fum;

  mdr_op_match #(
    .HI (`MDR_HI_ACC0_SGN),
    .MSB(`MDR_ACC0_OP_MSB),
    .LSB(`MDR_ACC0_OP_LSB),
    .VAL(`MDR_ACC0_OP_ADD)
  ) u_acc0_add (
    .word(base_word),
    .hit (h_acc0_add)
  );

  mdr_op_match #(
    .HI (`MDR_HI_ACC0_SGN),
    .MSB(`MDR_ACC0_OP_MSB),
    .LSB(`MDR_ACC0_OP_LSB),
    .VAL(`MDR_ACC0_OP_SUB)
  ) u_acc0_sub (
    .word(base_word),
    .hit (h_acc0_sub)
  );

  mdr_op_match #(
    .HI (`MDR_HI_ACC0_SAT),
    .MSB(`MDR_ACC0_OP_MSB),
    .LSB(`MDR_ACC0_OP_LSB),
    .VAL(`MDR_ACC0_OP_SUB)
  ) u_acc0_sat (
    .word(base_word),
    .hit (h_acc0_sat)
  );

  mdr_op_match #(
    .HI (`MDR_HI_ACC1_SGN),
    .MSB(`MDR_ACC1_OP_MSB),
    .LSB(`MDR_ACC1_OP_LSB),
    .VAL(`MDR_ACC1_OP_FIX)
  ) u_acc1_sgn (
    .word(base_word),
    .hit (h_acc1_sgn)
  );

  mdr_op_match #(
    .HI (`MDR_HI_ACC1_SGNM),
    .MSB(`MDR_ACC1_OP_MSB),
    .LSB(`MDR_ACC1_OP_LSB),
    .VAL(`MDR_ACC1_OP_FIX)
  ) u_acc1_sgnm (
    .word(base_word),
    .hit (h_acc1_sgnm)
  );

  mdr_op_match #(
    .HI (`MDR_HI_ACC1_S2M),
    .MSB(`MDR_ACC1_OP_MSB),
    .LSB(`MDR_ACC1_OP_LSB),
    .VAL(`MDR_ACC1_OP_FIX)
  ) u_acc1_s2m (
    .word(base_word),
    .hit (h_acc1_s2m)
  );

  mdr_op_match #(
    .HI (`MDR_HI_ACC1_FUM),
    .MSB(`MDR_ACC1_OP_MSB),
    .LSB(`MDR_ACC1_OP_LSB),
    .VAL(`MDR_ACC1_OP_FIX)
  ) u_acc1_fum (
    .word(base_word),
    .hit (h_acc1_fum)
  );

  // ***************************************************************
  // Operation attributes
  // ***************************************************************
  wire logic grp_acc0 = h_acc0_add | h_acc0_sub | h_acc0_sat;
  wire logic grp_acc1 = h_acc1_sgn | h_acc1_sgnm | h_acc1_s2m | h_acc1_fum;
  wire logic sub_op   = h_acc0_sub | h_acc0_sat | h_acc1_fum;
  wire logic mix_op   = h_acc1_sgnm | h_acc1_s2m | h_acc1_fum;

  mdr_pkg::mdr_option_t opt;
  assign opt = h_acc0_sat ? mdr_pkg::MDR_OPT_INT_SAT_X2 :
               h_acc1_s2m ? mdr_pkg::MDR_OPT_SCALE2_RND :
               h_acc1_fum ? mdr_pkg::MDR_OPT_FRAC_UNSGN :
                            mdr_pkg::MDR_OPT_INT_SIGNED;

  mdr_pkg::mdr_fields_t flds;

  mdr_field_split u_fields (
    .word   (base_word),
    .acc_one(grp_acc1),
    .fields (flds)
  );

  // Even destination for accumulator zero, odd for accumulator one
  wire logic parity_ok = grp_acc1 ? flds.dst[0] : ~flds.dst[0];
  wire logic par_ok    = ~par_form | par_en;
  wire logic known     = (grp_acc0 | grp_acc1) & parity_ok & par_ok;

  mdr_pkg::mdr_dec_t nxt_dec;

  always_comb begin
    nxt_dec          = '0;
    nxt_dec.known    = known;
    nxt_dec.parallel = par_form & known;
    nxt_dec.acc_one  = grp_acc1;
    nxt_dec.subtract = sub_op;
    nxt_dec.mixed    = mix_op;
    nxt_dec.option   = opt;
    nxt_dec.fields   = flds;
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  wire logic [31:0] rd_res = {{(32 - $bits(mdr_pkg::mdr_dec_t)){1'b0}},
                              dec_ff};
  wire logic [31:0] rd_hits = 32'(hits_ff);
  wire logic [31:0] rd_miss = 32'(miss_ff);
  wire logic [31:0] nxt_prdata =
    sel_ctrl ? ctrl_ff   :
    sel_inj  ? inject_ff :
    sel_word ? word_ff   :
    sel_res  ? rd_res    :
    sel_hits ? rd_hits   :
    sel_miss ? rd_miss   : 32'h0000_0000;

  // Unmapped offsets and writes to read-only words report an error
  wire logic nxt_err = ~mapped | (pwrite & ro_sel);

  // ***************************************************************
  // Bus answer: one wait state in every access
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff  <= acc_ph & ~pready_ff;
      pslverr_ff <= acc_ph & ~pready_ff & nxt_err;
      prdata_ff  <= (acc_ph & ~pready_ff & ~pwrite) ? nxt_prdata
                                                   : 32'h0000_0000;
    end
  end

  // ***************************************************************
  // Software registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= `MDR_CTRL_RST;
      inject_ff <= 32'h0000_0000;
      pend_ff   <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_inj) begin
        inject_ff <= nxt_inj;
      end
      pend_ff <= wr_inj | (pend_ff & ~take_inj);
    end
  end

  // ***************************************************************
  // Decode result and counters; a clear and a new count in one cycle leave a count of one
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid_ff <= 1'b0;
      dec_ff       <= '0;
      word_ff      <= 32'h0000_0000;
      hits_ff      <= '0;
      miss_ff      <= '0;
    end else if (ce) begin
      dec_valid_ff <= take;
      if (take) begin
        dec_ff  <= nxt_dec;
        word_ff <= src_word;
      end
      if (take & known) begin
        hits_ff <= (clr_hits ? '0 : hits_ff) + CW'(1);
      end else if (clr_hits) begin
        hits_ff <= '0;
      end
      if (take & ~known) begin
        miss_ff <= (clr_miss ? '0 : miss_ff) + CW'(1);
      end else if (clr_miss) begin
        miss_ff <= '0;
      end
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign dec_valid = dec_valid_ff;
  assign dec       = dec_ff;

endmodule : mdr_decoder

`default_nettype wire

// [pkg/mdr_cfg.svh]
// Constants for the multiply-accumulate to data register decoder
`ifndef MDR_CFG_SVH
`define MDR_CFG_SVH

// Parallel-issue marker: 0x0800_0000 added to the normal opcode
`define MDR_PAR_BIT      27

// Upper opcode halves of the recognised forms
`define MDR_HI_ACC0_SGN    16'hc10d
`define MDR_HI_ACC0_SAT    16'hc12d
`define MDR_HI_ACC1_SGN    16'hc109
`define MDR_HI_ACC1_SGNM   16'hc119
`define MDR_HI_ACC1_S2M    16'hc039
`define MDR_HI_ACC1_FUM    16'hc09a

// Fixed bits of the lower half, accumulator-zero layout
`define MDR_ACC0_OP_MSB    15
`define MDR_ACC0_OP_LSB    11
`define MDR_ACC0_OP_ADD    5'h01
`define MDR_ACC0_OP_SUB    5'h02
`define MDR_ACC0_HALF_MSB  10
`define MDR_ACC0_HALF_LSB  9

// Fixed bits of the lower half, accumulator-one layout
`define MDR_ACC1_OP_MSB    13
`define MDR_ACC1_OP_LSB    9
`define MDR_ACC1_OP_FIX    5'h0c
`define MDR_ACC1_HALF_MSB  15
`define MDR_ACC1_HALF_LSB  14

// Register select fields, common to both layouts
`define MDR_DST_MSB      8
`define MDR_DST_LSB      6
`define MDR_SRC0_MSB     5
`define MDR_SRC0_LSB     3
`define MDR_SRC1_MSB     2
`define MDR_SRC1_LSB     0

// Register map, byte addresses
`define MDR_OFS_CTRL     12'h000
`define MDR_OFS_INJECT   12'h004
`define MDR_OFS_WORD     12'h008
`define MDR_OFS_RESULT   12'h00c
`define MDR_OFS_HITS     12'h010
`define MDR_OFS_MISSES   12'h014

// Control register: bit 0 decode enable, bit 1 parallel form accepted
`define MDR_CTRL_RST     32'h0000_0003
`define MDR_CTRL_EN_BIT  0
`define MDR_CTRL_PAR_BIT 1

`endif

// [pkg/mdr_pkg.sv]
// Types shared by the decoder files
package mdr_pkg;

  typedef enum logic [1:0] {
    MDR_OPT_INT_SIGNED  = 2'h0,
    MDR_OPT_INT_SAT_X2  = 2'h1,
    MDR_OPT_SCALE2_RND  = 2'h2,
    MDR_OPT_FRAC_UNSGN  = 2'h3
  } mdr_option_t;

  typedef enum logic [1:0] {
    MDR_HALF_LO_LO = 2'h0,
    MDR_HALF_LO_HI = 2'h1,
    MDR_HALF_HI_LO = 2'h2,
    MDR_HALF_HI_HI = 2'h3
  } mdr_half_t;

  typedef struct packed {
    logic [2:0] dst;
    logic [2:0] src0;
    logic [2:0] src1;
    mdr_half_t  half;
  } mdr_fields_t;

  typedef struct packed {
    logic        known;
    logic        parallel;
    logic        acc_one;
    logic        subtract;
    logic        mixed;
    mdr_option_t option;
    mdr_fields_t fields;
  } mdr_dec_t;

endpackage : mdr_pkg

// [logic/mdr_op_match.sv]
// Matcher for one opcode form: upper half and a fixed lower-half field
`timescale 1ns/1ps
`default_nettype none

module mdr_op_match #(
  parameter logic [15:0] HI  = 16'h0000,
  parameter int          MSB = 4,
  parameter int          LSB = 0,
  parameter logic [4:0]  VAL = 5'h00
) (
  input  wire logic [31:0] word,
  output wire logic        hit
);

  assign hit = (word[31:16] == HI) && (word[MSB:LSB] == VAL);

endmodule : mdr_op_match

`default_nettype wire

// [logic/mdr_field_split.sv]
// Register and half-select fields of either accumulator layout
`timescale 1ns/1ps
`include "mdr_cfg.svh"
`default_nettype none

module mdr_field_split (
  input  wire logic               [31:0] word,
  input  wire logic                      acc_one,
  output mdr_pkg::mdr_fields_t           fields
);

  wire logic [1:0] half_acc0 = word[`MDR_ACC0_HALF_MSB:`MDR_ACC0_HALF_LSB];
  wire logic [1:0] half_acc1 = word[`MDR_ACC1_HALF_MSB:`MDR_ACC1_HALF_LSB];

  assign fields.half = mdr_pkg::mdr_half_t'(acc_one ? half_acc1
                                                     : half_acc0);
  assign fields.dst  = word[`MDR_DST_MSB:`MDR_DST_LSB];
  assign fields.src0 = word[`MDR_SRC0_MSB:`MDR_SRC0_LSB];
  assign fields.src1 = word[`MDR_SRC1_MSB:`MDR_SRC1_LSB];

endmodule : mdr_field_split

`default_nettype wire

// [verif/mdr_fetch_model.sv]
// Fetch stage model feeding instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none

module mdr_fetch_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic             insn_valid,
  output logic [31:0]      insn_word
);
  logic [31:0] q[$];
  logic        slow = 1'h0;

  // One queued word per cycle; random gaps when slow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_valid <= 1'h0;
      insn_word <= 32'h0;
    end else if (q.size() != 0 && !(slow && $urandom_range(1, 0) == 1)) begin
      insn_valid <= 1'h1;
      insn_word <= q.pop_front();
    end else begin
      insn_valid <= 1'h0;
      insn_word <= ~insn_word;
    end
  end
endmodule : mdr_fetch_model

`default_nettype wire

// [verif/mdr_decoder_monitor.sv]
// Port checker for the decoder, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module mdr_decoder_monitor #(
  parameter int AW = 12,
  parameter int CW = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [AW-1:0]     paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              insn_valid,
  input wire logic [31:0]       insn_word,
  input wire logic              dec_valid,
  input wire mdr_pkg::mdr_dec_t dec
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup; psel && !penable && ce; endsequence
  sequence s_access; psel && penable && ce; endsequence
  sequence s_fetch;
    dec_valid && dec.known && $past(insn_valid) && $past(ce);
  endsequence

  a_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_once: assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_dec_hold: assert property (!dec_valid |-> $stable(dec))
    else $error("dec changed without dec_valid");
  a_par_flag: assert property (
    s_fetch |-> dec.parallel == $past(insn_word[27]))
    else $error("parallel flag wrong");
  a_half_sel: assert property (
    s_fetch |-> dec.fields.half == (dec.acc_one ? $past(insn_word[15:14])
                                                : $past(insn_word[10:9])))
    else $error("half select wrong");
  a_dst_sel: assert property (
    s_fetch |-> dec.fields.dst == $past(insn_word[8:6]))
    else $error("destination wrong");
  a_left_sel: assert property (
    s_fetch |-> dec.fields.src0 == $past(insn_word[5:3]))
    else $error("left operand wrong");
  a_right_sel: assert property (
    s_fetch |-> dec.fields.src1 == $past(insn_word[2:0]))
    else $error("right operand wrong");
  a_even_dst: assert property (
    dec_valid && dec.known && !dec.acc_one |-> !dec.fields.dst[0])
    else $error("accumulator zero result to odd register");
  a_odd_dst: assert property (
    dec_valid && dec.known && dec.acc_one |-> dec.fields.dst[0])
    else $error("accumulator one result to even register");
  a_sat_sub: assert property (
    s_fetch ##0 dec.option == mdr_pkg::MDR_OPT_INT_SAT_X2
      |-> dec.subtract && !dec.acc_one)
    else $error("saturate form decoded wrong");
  a_scale_add: assert property (
    s_fetch ##0 dec.option == mdr_pkg::MDR_OPT_SCALE2_RND
      |-> !dec.subtract && dec.acc_one && dec.mixed)
    else $error("scale round form decoded wrong");
  a_frac_sub: assert property (
    s_fetch ##0 dec.option == mdr_pkg::MDR_OPT_FRAC_UNSGN
      |-> dec.subtract && dec.acc_one && dec.mixed)
    else $error("fraction form decoded wrong");
endmodule : mdr_decoder_monitor

bind mdr_decoder mdr_decoder_monitor #(.AW(AW), .CW(CW)) u_mon (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .insn_valid(insn_valid), .insn_word(insn_word),
  .dec_valid(dec_valid), .dec(dec)
);

`default_nettype wire

// [verif/mdr_decoder_tb_top.sv]
// Testbench: fetch model, APB master and reference decode
`timescale 1ns/1ps
`default_nettype none

module mdr_decoder_tb_top;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic insn_valid;
  logic [31:0] insn_word;
  logic dec_valid;
  mdr_pkg::mdr_dec_t dec;
  mdr_pkg::mdr_dec_t sd;
  logic [32:0] expq[$];
  logic [32:0] sw;
  logic [31:0] last_w;
  logic par_ok = 1'h1;
  logic [15:0] hi_tab[6] = '{16'hc10d, 16'hc12d, 16'hc109,
                             16'hc119, 16'hc039, 16'hc09a};
  int err_count = 0;
  int tests_run = 0;
  int hits = 0;
  int misses = 0;

  always #10 pclk = ~pclk;

  mdr_decoder DUT (
    .pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .insn_valid(insn_valid), .insn_word(insn_word),
    .dec_valid(dec_valid), .dec(dec)
  );

  mdr_fetch_model fm (
    .pclk(pclk), .presetn(presetn),
    .insn_valid(insn_valid), .insn_word(insn_word)
  );

  // ****************************************
  // Reference decode and checking
  // ****************************************
  function automatic mdr_pkg::mdr_dec_t ref_dec(logic [31:0] w, logic pok);
    mdr_pkg::mdr_dec_t d;
    logic acc1;
    d = '0;
    acc1 = (w[13:9] == 5'h0c);
    d.parallel = w[27];
    d.fields.dst = w[8:6];
    d.fields.src0 = w[5:3];
    d.fields.src1 = w[2:0];
    case (w[31:16] & 16'hf7ff)
      16'hc10d: d.known = (w[15:11] == 5'h01 || w[15:11] == 5'h02);
      16'hc12d: d.known = (w[15:11] == 5'h02);
      16'hc109, 16'hc119, 16'hc039, 16'hc09a: d.known = acc1;
      default: d.known = 1'h0;
    endcase
    d.subtract = (w[31:16] & 16'hf7ff) == 16'hc09a || w[15:11] == 5'h02;
    d.acc_one = w[23:16] != 8'h0d && w[23:16] != 8'h2d;
    d.mixed = d.acc_one && w[20];
    if (w[23:16] == 8'h2d) d.option = mdr_pkg::MDR_OPT_INT_SAT_X2;
    if (w[23:16] == 8'h39) d.option = mdr_pkg::MDR_OPT_SCALE2_RND;
    if (w[23:16] == 8'h9a) d.option = mdr_pkg::MDR_OPT_FRAC_UNSGN;
    if (d.acc_one) d.subtract = w[23:16] == 8'h9a;
    d.fields.half = mdr_pkg::mdr_half_t'(d.acc_one ? w[15:14] : w[10:9]);
    if (d.fields.dst[0] != d.acc_one || (w[27] && !pok)) d.known = 1'h0;
    return d;
  endfunction : ref_dec

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  always @(negedge pclk) begin
    if (dec_valid === 1'h1) begin
      if (expq.size() == 0) begin
        chk("dec_valid", 32'h1, 32'h0);
      end else begin
        sw = expq.pop_front();
        sd = ref_dec(sw[31:0], sw[32]);
        chk("known", {31'h0, dec.known}, {31'h0, sd.known});
        if (sd.known) begin
          chk("dec", {14'h0, dec}, {14'h0, sd});
          hits++;
        end else begin
          misses++;
        end
        last_w = sw[31:0];
      end
    end
  end

  // ****************************************
  // Bus master and stimulus
  // ****************************************
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1 && ++n < 40);
    if (n >= 40) chk("pready", 32'h0, 32'h1);
    chk("pslverr", {31'h0, pslverr}, {31'h0, ee});
    if (!w) chk("prdata", prdata, ed);
    psel <= 1'h0;
    penable <= 1'h0;
    if (w && a == 12'h004) expq.push_back({par_ok, d});
    if (w && a == 12'h000) par_ok = d[1];
  endtask : acc

  task automatic run_words(input int n);
    logic [31:0] w;
    @(negedge pclk);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      w[31:16] = hi_tab[i % 6];
      if (i % 6 < 2) w[15:11] = 5'($urandom_range(2, 1));
      else w[13:9] = 5'h0c;
      if (i % 13 == 0) w[31:16] = 16'($urandom);
      if (i % 4 == 0) w = w | 32'h0800_0000;
      fm.q.push_back(w);
      expq.push_back({par_ok, w});
    end
    for (int k = 0; k < 900 && expq.size() != 0; k++) @(posedge pclk);
    chk("drained", expq.size(), 32'h0);
  endtask : run_words

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    #50us;
    err_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(39));
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    acc(1'h0, 12'h000, 32'h0, 32'h3, 1'h0);
    acc(1'h0, 12'h018, 32'h0, 32'h0, 1'h1);
    acc(1'h1, 12'h008, 32'h1, 32'h0, 1'h1);
    acc(1'h0, 12'h010, 32'h0, 32'h0, 1'h0);
    $display("test registers done");
    run_words(240);
    fm.slow = 1'h1;
    run_words(60);
    fm.slow = 1'h0;
    acc(1'h0, 12'h010, 32'h0, 32'(hits), 1'h0);
    acc(1'h0, 12'h014, 32'h0, 32'(misses), 1'h0);
    acc(1'h0, 12'h008, 32'h0, last_w, 1'h0);
    $display("test decode done");
    acc(1'h1, 12'h004, 32'hc119_d8ea, 32'h0, 1'h0);
    repeat (4) @(posedge pclk);
    acc(1'h0, 12'h00c, 32'h0, {14'h0, ref_dec(32'hc119_d8ea, 1'h1)}, 1'h0);
    $display("test inject done");
    acc(1'h1, 12'h000, 32'h0, 32'h0, 1'h0);
    @(negedge pclk);
    fm.q.push_back(32'hc10d_0800);
    repeat (6) @(posedge pclk);
    acc(1'h1, 12'h000, 32'h1, 32'h0, 1'h0);
    run_words(24);
    acc(1'h1, 12'h000, 32'h3, 32'h0, 1'h0);
    acc(1'h1, 12'h010, 32'h0, 32'h0, 1'h0);
    acc(1'h0, 12'h010, 32'h0, 32'h0, 1'h0);
    $display("test control done");
    give_verdict();
  end
endmodule : mdr_decoder_tb_top

`default_nettype wire
